//--- verilog/pcr_pkg.sv
// constants for the switch port configuration register bank
package pcr_pkg;

  // ----------------------------------------------------------------
  // dword offsets of the register bank
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_SLOT_EVT = 12'h080;
  localparam logic [11:0] OFF_DEV_CAP2 = 12'h08c;
  localparam logic [11:0] OFF_DEV_CTL2 = 12'h090;
  localparam logic [11:0] OFF_LNK_CAP2 = 12'h094;
  localparam logic [11:0] OFF_LNK_CTL2 = 12'h098;
  localparam logic [11:0] OFF_SLT_CAP2 = 12'h09c;
  localparam logic [11:0] OFF_SLT_CTL2 = 12'h0a0;
  localparam logic [11:0] OFF_SS_HDR = 12'h0a4;
  localparam logic [11:0] OFF_SS_CODE = 12'h0a8;
  localparam logic [11:0] OFF_BAR_CFG = 12'h0e4;
  localparam logic [11:0] OFF_SN_HDR = 12'h100;
  localparam logic [11:0] OFF_SN_LO = 12'h104;
  localparam logic [11:0] OFF_SN_HI = 12'h108;
  localparam logic [11:0] OFF_PB_HDR = 12'h138;
  localparam logic [11:0] OFF_PB_SEL = 12'h13c;
  localparam logic [11:0] OFF_PB_DATA = 12'h140;
  localparam logic [11:0] OFF_PB_ALLOC = 12'h144;
  localparam logic [11:0] OFF_VC_HDR = 12'h148;
  localparam logic [11:0] OFF_VC_CAP1 = 12'h14c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 6;
  localparam int POS_FLAG0 = 16;
  localparam int POS_DLL_CHG = 24;
  localparam int POS_LATCH = 21;
  localparam int POS_PRESENT = 22;
  localparam int POS_INTERLOCK = 23;
  localparam int POS_ARI = 5;
  localparam int POS_COMPL = 4;
  localparam int POS_AUTOSPD = 5;
  localparam int POS_DEEMPH = 6;
  localparam int POS_MARGIN = 7;
  localparam int POS_MODCOMPL = 10;
  localparam int POS_SKIPSET = 11;
  localparam int POS_COMPL_DE = 12;
  localparam int POS_CUR_DE = 16;
  localparam int POS_BAR_PF = 2;
  localparam int POS_NEXT = 20;
  localparam int POS_VERSION = 16;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;
  localparam logic [2:0] MARGIN_RST = 3'h0;
  localparam logic [1:0] BAR_OFF = 2'h0;
  localparam logic [1:0] BAR_RSVD = 2'h1;
  localparam logic [1:0] BAR_32 = 2'h2;
  localparam logic [7:0] SS_CAP_ID = 8'h0d;
  localparam logic [7:0] SS_NEXT = 8'h00;
  localparam logic [15:0] SN_CAP_ID = 16'h0003;
  localparam logic [15:0] PB_CAP_ID = 16'h0004;
  localparam logic [15:0] VC_CAP_ID = 16'h0002;
  localparam logic [3:0] CAP_VER = 4'h1;
  localparam logic [11:0] SN_NEXT_RST = 12'hfb4;
  localparam logic [11:0] PB_NEXT = 12'h148;
  localparam logic [11:0] VC_NEXT_UP = 12'h270;
  localparam logic [11:0] VC_NEXT_DN = 12'h520;
  localparam logic [7:0] PB_SEL_MAX = 8'h00;
  localparam logic [7:0] PB_SEL_SUST = 8'h01;
  // budget word: rail[20:18] type[17:15] state[14:13] sub[12:10] scale[9:8] base[7:0]
  localparam logic [31:0] PB_WORD_MAX = 32'h000b_8004;
  localparam logic [31:0] PB_WORD_SUST = 32'h0009_8003;
  localparam logic [31:0] PB_ALLOC_WORD = 32'h0000_0001;
  localparam logic [31:0] VC_CAP1_WORD = 32'h0000_0800;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // subsystem codes: arbitrary neutral values
  localparam logic [15:0] SS_VENDOR_RST = 16'h1a2b;
  localparam logic [15:0] SS_DEVICE_RST = 16'h3c4d;

endpackage

//--- verilog/pcr_port_regs.sv
// one switch port's configuration register bank with hot-plug status flags
//
// Contract
// - slot status bits 16..20 latch hot-plug events until software writes one
// - command-completed bit 20 sets when the hot-plug controller finishes a command
// - bit 21 is read-only latch sensor state, one when open
// - bit 22 shows card presence; reads one on ports without a slot
// - bit 23 is read-only interlock state, one when engaged
// - bit 24 sets on any change of link-active, cleared by writing one
// - routing-ID forwarding supported bit: zero upstream, one downstream, strappable
// - routing-ID forwarding enable, read-write on downstream ports, resets zero
// - target speed accepts 2.5 and 5.0 codes only, resets to 5.0
// - link control 2 bit 4 requests compliance mode, resets zero
// - bit 6 selects de-emphasis, one downstream and zero upstream by default
// - link status 2 bit 16 shows de-emphasis in use, one means -6 dB
// - bits 10..12 act upstream only; transmit margin resets to zero
// - subsystem capability header reads ID 0Dh and next pointer 00h
// - upstream window type field: off, reserved, 32-bit, 64-bit; resets 32-bit
// - window prefetchable bit, resets to zero
// - serial-number header: ID 0003h, version 1, next FB4h, next strappable
// - serial-number dwords read-only, strap loadable, reset to zero
// - upstream power budgeting header: ID 0004h, version 1, next 148h
// - budget index 00h selects max, 01h sustained, others report zero
// - budget data follows index with fixed base power, type, rail, D0 state
// - virtual channel header: ID 0002h, version 1, next 270h up, 520h down
// - link-active follows the data link state machine's active state
module pcr_port_regs
  import pcr_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic strap_wr,
  input wire logic [11:0] strap_addr,
  input wire logic [31:0] strap_data,
  input wire logic slot_implemented,
  input wire logic attn_button_evt,
  input wire logic power_fault_evt,
  input wire logic latch_change_evt,
  input wire logic presence_change_evt,
  input wire logic command_done_evt,
  input wire logic latch_open,
  input wire logic card_present,
  input wire logic electromech_interlock,
  input wire logic dl_state_active,
  input wire logic deemph_in_use,
  output logic ari_forward_en,
  output logic [3:0] target_speed,
  output logic enter_compliance,
  output logic autonomous_speed_disable,
  output logic select_deemph,
  output logic [2:0] tx_margin,
  output logic modified_compliance,
  output logic compliance_skip_sets,
  output logic compliance_deemph,
  output logic [1:0] first_base_window_type,
  output logic first_base_window_prefetch
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flags_q;
  logic link_active_q;
  logic link_active_prev_q;
  logic ari_support_q;
  logic [11:0] sn_next_q;
  logic [31:0] sn_lo_q;
  logic [31:0] sn_hi_q;
  logic [11:0] vc_next_q;
  logic [15:0] ss_vendor_q;
  logic [15:0] ss_device_q;
  logic [7:0] pb_sel_q;
  logic [31:0] rdata_q;
  logic rvalid_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  wire up = IS_UPSTREAM;
  wire dn = ~IS_UPSTREAM;
  wire hit_slot = hit(cfg_addr, OFF_SLOT_EVT) & dn;
  wire hit_dcap = hit(cfg_addr, OFF_DEV_CAP2);
  wire hit_dctl = hit(cfg_addr, OFF_DEV_CTL2);
  wire hit_lctl = hit(cfg_addr, OFF_LNK_CTL2);
  wire hit_sshdr = hit(cfg_addr, OFF_SS_HDR);
  wire hit_sscode = hit(cfg_addr, OFF_SS_CODE);
  wire hit_bar = hit(cfg_addr, OFF_BAR_CFG) & up;
  wire hit_snhdr = hit(cfg_addr, OFF_SN_HDR);
  wire hit_snlo = hit(cfg_addr, OFF_SN_LO);
  wire hit_snhi = hit(cfg_addr, OFF_SN_HI);
  wire hit_pbhdr = hit(cfg_addr, OFF_PB_HDR) & up;
  wire hit_pbsel = hit(cfg_addr, OFF_PB_SEL) & up;
  wire hit_pbdata = hit(cfg_addr, OFF_PB_DATA) & up;
  wire hit_pballoc = hit(cfg_addr, OFF_PB_ALLOC) & up;
  wire hit_vchdr = hit(cfg_addr, OFF_VC_HDR);
  wire hit_vccap = hit(cfg_addr, OFF_VC_CAP1);

  // strap loads reach fields that configuration writes cannot touch, and also the writable de-emphasis select and window fields
  wire st_dcap = strap_wr & hit(strap_addr, OFF_DEV_CAP2);
  wire st_lctl = strap_wr & hit(strap_addr, OFF_LNK_CTL2);
  wire st_ss = strap_wr & hit(strap_addr, OFF_SS_CODE);
  wire st_bar = strap_wr & hit(strap_addr, OFF_BAR_CFG) & up;
  wire st_snhdr = strap_wr & hit(strap_addr, OFF_SN_HDR);
  wire st_snlo = strap_wr & hit(strap_addr, OFF_SN_LO);
  wire st_snhi = strap_wr & hit(strap_addr, OFF_SN_HI);
  wire st_vchdr = strap_wr & hit(strap_addr, OFF_VC_HDR);

  // byte-lane qualified configuration writes
  wire wr_b0 = cfg_wr & cfg_be[0];
  wire wr_b1 = cfg_wr & cfg_be[1];
  wire wr_slot2 = cfg_wr & cfg_be[2] & hit_slot;
  wire wr_slot3 = cfg_wr & cfg_be[3] & hit_slot;
  wire wr_dctl = wr_b0 & hit_dctl & dn;
  wire wr_lctl0 = wr_b0 & hit_lctl;
  wire wr_lctl1 = wr_b1 & hit_lctl;
  wire wr_bar = wr_b0 & hit_bar;
  wire wr_pbsel = wr_b0 & hit_pbsel;

  // ----------------------------------------------------------------
  // hot-plug event flags
  // ----------------------------------------------------------------
  // link-active changes of either polarity are an event
  wire dll_change = link_active_q ^ link_active_prev_q;
  wire [NUM_FLAGS-1:0] flag_set = {dll_change, command_done_evt, presence_change_evt,
                                   latch_change_evt, power_fault_evt, attn_button_evt};

  // one flip-flop per flag; set is tested first so it wins over a clear
  for (genvar i = 0; i < NUM_FLAGS; i++)
  begin : g_flag
    localparam int POS = (i == NUM_FLAGS - 1) ? POS_DLL_CHG : POS_FLAG0 + i;
    wire clr = ((POS < POS_DLL_CHG) ? wr_slot2 : wr_slot3) & cfg_wdata[POS];
    always_ff @(posedge clk)
    begin
      if (rst)
        flags_q[i] <= 1'b0;
      else if (flag_set[i] & dn)
        flags_q[i] <= 1'b1;
      else if (clr)
        flags_q[i] <= 1'b0;
    end
  end

  // link-active is sampled from the data link state machine each cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_active_q <= 1'b0;
      link_active_prev_q <= 1'b0;
    end
    else
    begin
      link_active_q <= dl_state_active;
      link_active_prev_q <= link_active_q;
    end
  end

  // ----------------------------------------------------------------
  // device and link control 2
  // ----------------------------------------------------------------
  // reserved speed codes are dropped so the field always holds a legal code
  wire speed_ok = (cfg_wdata[3:0] == SPEED_2G5) | (cfg_wdata[3:0] == SPEED_5G0);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ari_support_q <= dn;
      ari_forward_en <= 1'b0;
      target_speed <= SPEED_5G0;
      enter_compliance <= 1'b0;
      autonomous_speed_disable <= 1'b0;
      select_deemph <= dn;
      tx_margin <= MARGIN_RST;
    end
    else
    begin
      if (st_dcap)
        ari_support_q <= strap_data[POS_ARI];
      if (wr_dctl)
        ari_forward_en <= cfg_wdata[POS_ARI];
      if (wr_lctl0 & speed_ok)
        target_speed <= cfg_wdata[3:0];
      if (wr_lctl0)
      begin
        enter_compliance <= cfg_wdata[POS_COMPL];
        autonomous_speed_disable <= cfg_wdata[POS_AUTOSPD];
        tx_margin[0] <= cfg_wdata[POS_MARGIN];
      end
      // the de-emphasis choice only matters for a downstream transmitter
      if (st_lctl)
        select_deemph <= strap_data[POS_DEEMPH];
      else if (wr_lctl0 & dn)
        select_deemph <= cfg_wdata[POS_DEEMPH];
      if (wr_lctl1)
        tx_margin[2:1] <= cfg_wdata[POS_MARGIN+2:POS_MARGIN+1];
    end
  end

  // compliance variants are writable only on the upstream port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      modified_compliance <= 1'b0;
      compliance_skip_sets <= 1'b0;
      compliance_deemph <= 1'b0;
    end
    else if (wr_lctl1 & up)
    begin
      modified_compliance <= cfg_wdata[POS_MODCOMPL];
      compliance_skip_sets <= cfg_wdata[POS_SKIPSET];
      compliance_deemph <= cfg_wdata[POS_COMPL_DE];
    end
  end

  // ----------------------------------------------------------------
  // window configuration and power budget index
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_base_window_type <= BAR_32;
      first_base_window_prefetch <= 1'b0;
      pb_sel_q <= PB_SEL_MAX;
    end
    else
    begin
      if (st_bar)
      begin
        if (strap_data[1:0] != BAR_RSVD)
          first_base_window_type <= strap_data[1:0];
        first_base_window_prefetch <= strap_data[POS_BAR_PF];
      end
      else if (wr_bar)
      begin
        if (cfg_wdata[1:0] != BAR_RSVD)
          first_base_window_type <= cfg_wdata[1:0];
        first_base_window_prefetch <= cfg_wdata[POS_BAR_PF];
      end
      if (wr_pbsel)
        pb_sel_q <= cfg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // strap-only fields
  // ----------------------------------------------------------------
  // configuration writes never reach these; only the loader does
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sn_next_q <= SN_NEXT_RST;
      sn_lo_q <= ZERO_WORD;
      sn_hi_q <= ZERO_WORD;
      vc_next_q <= up ? VC_NEXT_UP : VC_NEXT_DN;
      ss_vendor_q <= SS_VENDOR_RST;
      ss_device_q <= SS_DEVICE_RST;
    end
    else
    begin
      if (st_snhdr)
        sn_next_q <= strap_data[31:POS_NEXT];
      if (st_snlo)
        sn_lo_q <= strap_data;
      if (st_snhi)
        sn_hi_q <= strap_data;
      if (st_vchdr)
        vc_next_q <= strap_data[31:POS_NEXT];
      if (st_ss)
      begin
        ss_vendor_q <= strap_data[15:0];
        ss_device_q <= strap_data[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  wire presence = slot_implemented ? card_present : 1'b1;
  wire [31:0] slot_word = {7'h00, flags_q[5], electromech_interlock, presence,
                           latch_open, flags_q[4:0], 16'h0000};
  wire [31:0] dcap_word = ZERO_WORD | (32'(ari_support_q) << POS_ARI);
  wire [31:0] dctl_word = ZERO_WORD | (32'(ari_forward_en) << POS_ARI);
  wire [31:0] lctl_word = {15'h0000, deemph_in_use, 3'h0, compliance_deemph,
                           compliance_skip_sets, modified_compliance, tx_margin,
                           select_deemph, autonomous_speed_disable, enter_compliance,
                           target_speed};
  wire [31:0] sshdr_word = {16'h0000, SS_NEXT, SS_CAP_ID};
  wire [31:0] bar_word = {29'h0000_0000, first_base_window_prefetch, first_base_window_type};
  wire [31:0] snhdr_word = {sn_next_q, CAP_VER, SN_CAP_ID};
  wire [31:0] pbhdr_word = {PB_NEXT, CAP_VER, PB_CAP_ID};
  wire [31:0] vchdr_word = {vc_next_q, CAP_VER, VC_CAP_ID};
  // an unsupported index reports an all-zero budget
  wire [31:0] pbdata_word = (pb_sel_q == PB_SEL_MAX) ? PB_WORD_MAX :
                            (pb_sel_q == PB_SEL_SUST) ? PB_WORD_SUST : ZERO_WORD;

  // and-or read mux; unmapped and absent offsets read zero
  wire [31:0] rd_mux =
      ({32{hit_slot}} & slot_word) |
      ({32{hit_dcap}} & dcap_word) |
      ({32{hit_dctl}} & dctl_word) |
      ({32{hit_lctl}} & lctl_word) |
      ({32{hit_sshdr}} & sshdr_word) |
      ({32{hit_sscode}} & {ss_device_q, ss_vendor_q}) |
      ({32{hit_bar}} & bar_word) |
      ({32{hit_snhdr}} & snhdr_word) |
      ({32{hit_snlo}} & sn_lo_q) |
      ({32{hit_snhi}} & sn_hi_q) |
      ({32{hit_pbhdr}} & pbhdr_word) |
      ({32{hit_pbsel}} & {24'h00_0000, pb_sel_q}) |
      ({32{hit_pbdata}} & pbdata_word) |
      ({32{hit_pballoc}} & PB_ALLOC_WORD) |
      ({32{hit_vchdr}} & vchdr_word) |
      ({32{hit_vccap}} & VC_CAP1_WORD);

  // read data is registered so the answer comes one cycle after the request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= ZERO_WORD;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= cfg_rd;
      if (cfg_rd)
        rdata_q <= rd_mux;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;

endmodule

//--- bench/pcr_port_regs_assertions.sv
// property checker for the switch port configuration register bank
module pcr_regs_chk
  import pcr_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic strap_wr,
  input wire logic ari_forward_en,
  input wire logic [3:0] target_speed,
  input wire logic enter_compliance,
  input wire logic select_deemph,
  input wire logic [1:0] first_base_window_type
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // decoded low-lane writes
  // ----------------------------------------------------------------
  // address bits 1:0 are don't-care, so only the dword index is compared
  wire logic lnk_wr = cfg_wr && cfg_be[0] && cfg_addr[11:2] == OFF_LNK_CTL2[11:2];
  wire logic dev_wr = cfg_wr && cfg_be[0] && cfg_addr[11:2] == OFF_DEV_CTL2[11:2];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // answer pulse follows every read and nothing else
  property p_rd_answer;
    1 |=> cfg_rvalid == $past(cfg_rd);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer pulse misplaced");
  // read data must not drift between answers
  property p_rdata_hold;
    !cfg_rvalid |-> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without answer");
  property p_spd_legal;
    target_speed == SPEED_2G5 || target_speed == SPEED_5G0;
  endproperty
  a_spd_legal: assert property (p_spd_legal) else $error("target speed holds a reserved code");
  property p_spd_slow;
    lnk_wr && cfg_wdata[3:0] == SPEED_2G5 |=> target_speed == SPEED_2G5;
  endproperty
  a_spd_slow: assert property (p_spd_slow) else $error("slow speed write not taken");
  property p_compl;
    lnk_wr && cfg_wdata[POS_COMPL] |=> enter_compliance;
  endproperty
  a_compl: assert property (p_compl) else $error("compliance request not taken");
  property p_ari;
    dev_wr && cfg_wdata[POS_ARI] && !IS_UPSTREAM |=> ari_forward_en;
  endproperty
  a_ari: assert property (p_ari) else $error("forwarding enable not taken");
  property p_win_type;
    first_base_window_type != BAR_RSVD;
  endproperty
  a_win_type: assert property (p_win_type) else $error("window type holds reserved code");
  // controls only move on a configuration write or a strap load
  property p_hold;
    !cfg_wr && !strap_wr |=> $stable(target_speed) && $stable(select_deemph) && $stable(ari_forward_en);
  endproperty
  a_hold: assert property (p_hold) else $error("control field changed without a write");

  c_read: cover property (cfg_rd ##1 cfg_rvalid);
  c_slow: cover property (lnk_wr && cfg_wdata[3:0] == SPEED_2G5);
  c_ari: cover property (dev_wr && cfg_wdata[POS_ARI]);
endmodule

bind pcr_port_regs pcr_regs_chk #(.IS_UPSTREAM(IS_UPSTREAM)) i_chk (
  .clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .strap_wr,
  .ari_forward_en, .target_speed, .enter_compliance, .select_deemph, .first_base_window_type
);

//--- bench/pcr_cfg_host.sv
// configuration-request host model for the register bank
module pcr_cfg_host
(
  input wire logic clk,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // one write per call; released byte enables and data are inverted so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_be = ~be;
    cfg_wdata = ~d;
  endtask

  // one read; the answer is awaited for a few cycles at most
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (cfg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        q = cfg_rdata;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the switch port configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pcr_pkg::*;

  logic clk = 1'b0;
  logic rst, cfg_wr, cfg_rd, cfg_rvalid, strap_wr, slot_implemented;
  logic [11:0] cfg_addr, strap_addr;
  logic [3:0] cfg_be, target_speed;
  logic [31:0] cfg_wdata, cfg_rdata, strap_data;
  logic [4:0] evt;
  logic latch_open, card_present, electromech_interlock, dl_state_active, deemph_in_use;
  logic ari_forward_en, enter_compliance, select_deemph;
  logic [2:0] tx_margin, compl_var;
  int mismatches, n_tests;

  always #5 clk = ~clk;

  // downstream port: window and budget registers are refused here
  pcr_port_regs #(.IS_UPSTREAM(1'b0)) i_dut (
    .clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .strap_wr, .strap_addr, .strap_data, .slot_implemented,
    .attn_button_evt(evt[0]), .power_fault_evt(evt[1]), .latch_change_evt(evt[2]),
    .presence_change_evt(evt[3]), .command_done_evt(evt[4]),
    .latch_open, .card_present, .electromech_interlock, .dl_state_active, .deemph_in_use,
    .ari_forward_en, .target_speed, .enter_compliance, .autonomous_speed_disable(), .select_deemph,
    .tx_margin, .modified_compliance(compl_var[0]), .compliance_skip_sets(compl_var[1]),
    .compliance_deemph(compl_var[2]),
    .first_base_window_type(), .first_base_window_prefetch()
  );
  pcr_cfg_host i_host (.clk, .cfg_rdata, .cfg_rvalid, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a missing answer ends the run at once
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bit ok;
    i_host.rd(a, q, ok);
    if (!ok)
    begin
      mismatches++;
      give_verdict();
    end
    else
      chk(q, exp);
  endtask

  task automatic strap(input logic [11:0] a, input logic [31:0] d);
    step();
    strap_wr = 1'b1;
    strap_addr = a;
    strap_data = d;
    step();
    strap_wr = 1'b0;
    strap_data = ~d;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    rd_chk(OFF_DEV_CAP2, 32'h0000_0020);
    rd_chk(OFF_DEV_CTL2, 32'h0000_0000);
    rd_chk(OFF_LNK_CTL2, 32'h0001_0042);
    chk(32'(target_speed), 32'h0000_0002);
    chk(32'(tx_margin), 32'h0000_0000);
    rd_chk(OFF_SS_HDR, 32'h0000_000d);
    rd_chk(OFF_SN_HDR, 32'hfb41_0003);
    rd_chk(OFF_SN_HI, 32'h0000_0000);
    rd_chk(OFF_VC_HDR, 32'h5201_0002);
    rd_chk(OFF_BAR_CFG, 32'h0000_0000);
    rd_chk(OFF_PB_DATA, 32'h0000_0000);
    rd_chk(12'h0f0, 32'h0000_0000);
  endtask

  // each event latches, survives a zero write, and clears on a one write
  task automatic t_flags();
    for (int i = 0; i < 5; i++)
    begin
      step();
      evt[i] = 1'b1;
      step();
      evt[i] = 1'b0;
      rd_chk(OFF_SLOT_EVT, 32'h0040_0000 | (32'h1 << (16 + i)));
      i_host.wr(OFF_SLOT_EVT, 4'h4, 32'h0000_0000);
      rd_chk(OFF_SLOT_EVT, 32'h0040_0000 | (32'h1 << (16 + i)));
      i_host.wr(OFF_SLOT_EVT, 4'h4, 32'h1 << (16 + i));
      rd_chk(OFF_SLOT_EVT, 32'h0040_0000);
    end
    // completion arriving in the very cycle of its clearing write
    step();
    evt[4] = 1'b1;
    i_host.wr(OFF_SLOT_EVT, 4'h4, 32'h0010_0000);
    evt[4] = 1'b0;
    rd_chk(OFF_SLOT_EVT, 32'h0050_0000);
    i_host.wr(OFF_SLOT_EVT, 4'h4, 32'h0010_0000);
    rd_chk(OFF_SLOT_EVT, 32'h0040_0000);
  endtask

  task automatic t_levels();
    step();
    latch_open = 1'b1;
    electromech_interlock = 1'b1;
    card_present = 1'b0;
    rd_chk(OFF_SLOT_EVT, 32'h00a0_0000);
    i_host.wr(OFF_SLOT_EVT, 4'hf, 32'h0000_0000);
    rd_chk(OFF_SLOT_EVT, 32'h00a0_0000);
    slot_implemented = 1'b0;
    rd_chk(OFF_SLOT_EVT, 32'h00e0_0000);
    slot_implemented = 1'b1;
    latch_open = 1'b0;
    electromech_interlock = 1'b0;
    card_present = 1'b1;
  endtask

  task automatic t_link();
    step();
    dl_state_active = 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFF_SLOT_EVT, 32'h0140_0000);
    i_host.wr(OFF_SLOT_EVT, 4'h4, 32'h0100_0000);
    rd_chk(OFF_SLOT_EVT, 32'h0140_0000);
    i_host.wr(OFF_SLOT_EVT, 4'h8, 32'h0100_0000);
    rd_chk(OFF_SLOT_EVT, 32'h0040_0000);
  endtask

  task automatic t_ctl();
    i_host.wr(OFF_LNK_CTL2, 4'h3, 32'h0000_1c21);
    chk(32'(target_speed), 32'h0000_0001);
    chk(32'(select_deemph), 32'h0000_0000);
    chk(32'(compl_var), 32'h0000_0000);
    rd_chk(OFF_LNK_CTL2, 32'h0001_0021);
    i_host.wr(OFF_LNK_CTL2, 4'h3, 32'h0000_0393);
    chk(32'(target_speed), 32'h0000_0001);
    chk(32'(enter_compliance), 32'h0000_0001);
    chk(32'(tx_margin), 32'h0000_0007);
    deemph_in_use = 1'b0;
    rd_chk(OFF_LNK_CTL2, 32'h0000_0391);
    i_host.wr(OFF_DEV_CTL2, 4'h1, 32'h0000_0020);
    chk(32'(ari_forward_en), 32'h0000_0001);
    i_host.wr(OFF_DEV_CAP2, 4'hf, 32'h0000_0000);
    rd_chk(OFF_DEV_CAP2, 32'h0000_0020);
  endtask

  task automatic t_strap();
    strap(OFF_SN_LO, 32'h1234_5678);
    i_host.wr(OFF_SN_LO, 4'hf, 32'h0000_0000);
    rd_chk(OFF_SN_LO, 32'h1234_5678);
    strap(OFF_SN_HDR, 32'h1230_0000);
    rd_chk(OFF_SN_HDR, 32'h1231_0003);
    strap(OFF_DEV_CAP2, 32'h0000_0000);
    rd_chk(OFF_DEV_CAP2, 32'h0000_0000);
  endtask

  // a second reset in mid-run must bring the controls home
  task automatic t_rerst();
    step();
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    chk(32'(target_speed), 32'h0000_0002);
    chk(32'(enter_compliance), 32'h0000_0000);
    chk(32'(select_deemph), 32'h0000_0001);
    chk(32'(ari_forward_en), 32'h0000_0000);
    rd_chk(OFF_SN_LO, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    strap_wr = 1'b0;
    strap_addr = 12'h000;
    strap_data = 32'h0000_0000;
    slot_implemented = 1'b1;
    evt = 5'h00;
    latch_open = 1'b0;
    card_present = 1'b1;
    electromech_interlock = 1'b0;
    dl_state_active = 1'b0;
    deemph_in_use = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_defaults();
    t_flags();
    t_levels();
    t_link();
    t_ctl();
    t_strap();
    t_rerst();
    give_verdict();
  end
endmodule
